// ### design/jbs_tester.sv
// Tester end: drives the link clock and walks reset, IR and DR scans.
// Assumes a user issues one sequence at a time with start while ready.
`timescale 1ns/1ns
`default_nettype none
module jbs_tester
	import jbs_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	jbs_if.tester_end link,
	input wire logic start,
	input wire jbs_op_t op,
	input wire logic [31:0] wdata,
	input wire logic [5:0] nbits,
	input wire logic hold_trst,
	output logic ready,
	output logic [31:0] rdata,
	output logic done
);
	// ==========================================================
	// Walk: preamble TMS bits, body shift bits, postamble TMS bits.
	logic [15:0] tms_seq;
	logic [4:0] seq_len;
	logic [4:0] step;
	logic [5:0] shift_left;
	logic [31:0] sh_out;
	logic busy;
	logic phase;
	logic [3:0] cnt;
	logic tck;
	logic tms;
	logic in_body;
	logic tdo_s1;
	logic tdo_s2;
	wire half_done = (cnt == JBS_HALF_CNT);
	wire pre_done = (step == seq_len);
	wire body_last = (shift_left == 6'h01);
	assign ready = ~busy;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tdo_s1 <= 1'b0;
			tdo_s2 <= 1'b0;
		end
		else
		begin
			tdo_s1 <= link.tdo;
			tdo_s2 <= tdo_s1;
		end
	end
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			busy <= 1'b0;
			phase <= 1'b0;
			cnt <= 4'h0;
			tck <= 1'b0;
			tms <= 1'b1;
			step <= 5'h00;
			seq_len <= 5'h00;
			tms_seq <= 16'h0000;
			shift_left <= 6'h00;
			sh_out <= 32'h00000000;
			rdata <= 32'h00000000;
			in_body <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (!busy && start)
			begin
				busy <= 1'b1;
				cnt <= 4'h0;
				phase <= 1'b0;
				step <= 5'h00;
				sh_out <= wdata;
				in_body <= 1'b0;
				shift_left <= (op == JBS_OP_RESET) ? 6'h00 : nbits;
				// Bits are sent LSB first from index zero.
				case (op)
					JBS_OP_RESET:
					begin
						tms_seq <= 16'h001F;
						seq_len <= 5'h06;
					end
					JBS_OP_IR:
					begin
						tms_seq <= 16'h0003;
						seq_len <= 5'h04;
					end
					default:
					begin
						tms_seq <= 16'h0001;
						seq_len <= 5'h03;
					end
				endcase
			end
			else if (busy)
			begin
				cnt <= half_done ? 4'h0 : cnt + 4'h1;
				if (half_done && !phase)
				begin
					// Settle TMS a quarter period and TDI a half period ahead of the rise.
					// The walk ends here, so no stray pulse leaves idle.
					if (pre_done && !in_body)
					begin
						busy <= 1'b0;
						done <= 1'b1;
					end
					else
					begin
						phase <= 1'b1;
						if (!pre_done)
							tms <= tms_seq[step[3:0]];
						else
							tms <= body_last;
					end
				end
				else if (half_done && phase)
				begin
					phase <= 1'b0;
					tck <= ~tck;
					if (tck)
					begin
						if (!pre_done)
						begin
							step <= step + 5'h01;
							if ((step + 5'h01) == seq_len)
								in_body <= (shift_left != 6'h00);
						end
						else if (in_body)
						begin
							rdata <= {tdo_s2, rdata[31:1]};
							sh_out <= {1'b0, sh_out[31:1]};
							shift_left <= shift_left - 6'h01;
							if (body_last)
							begin
								in_body <= 1'b0;
								step <= 5'h00;
								tms_seq <= 16'h0001;
								seq_len <= 5'h02;
							end
						end
					end
				end
			end
		end
	end
	assign link.tck = tck;
	assign link.tms = tms;
	assign link.tdi = sh_out[0];
	assign link.trst_n = ~hold_trst;
endmodule // jbs_tester
`default_nettype wire

// ### design/jbs_pkg.sv
// Shared constants and types for the test access port and its tester.
// Assumes both ends run on one 25 MHz system clock.
package jbs_pkg;
	// ==========================================================
	// Controller states
	typedef enum logic [3:0] {
		JBS_RESET, JBS_IDLE, JBS_SEL_DR, JBS_CAP_DR, JBS_SHIFT_DR,
		JBS_EXIT1_DR, JBS_PAUSE_DR, JBS_EXIT2_DR, JBS_UPD_DR,
		JBS_SEL_IR, JBS_CAP_IR, JBS_SHIFT_IR, JBS_EXIT1_IR,
		JBS_PAUSE_IR, JBS_EXIT2_IR, JBS_UPD_IR
	} jbs_state_t;
	// ==========================================================
	// Instruction register layout
	localparam int JBS_IR_W = 3;
	localparam logic [2:0] JBS_IR_BYPASS = 3'h7;
	localparam logic [2:0] JBS_IR_RESET = 3'h7;
	localparam logic [2:0] JBS_IR_CAPTURE = 3'h1;
	// ==========================================================
	// Tester timing: quarter period of the link clock in system cycles
	localparam int JBS_CLK_HZ = 25000000;
	localparam int JBS_TCK_HALF_NS = 160;
	localparam int JBS_TCK_HALF_CYC = (JBS_TCK_HALF_NS * (JBS_CLK_HZ / 1000000)) / 1000;
	localparam logic [3:0] JBS_HALF_CNT = 4'(JBS_TCK_HALF_CYC - 1);
	// Tester sequence kinds
	typedef enum logic [1:0] {
		JBS_OP_RESET, JBS_OP_IR, JBS_OP_DR
	} jbs_op_t;
	localparam logic [5:0] JBS_DR_MAX = 6'h20;
endpackage

// ### design/jbs_if.sv
// Link between the test access port and its tester.
// Assumes the bench resolves nothing: all pins are one-way here.
`timescale 1ns/1ns
`default_nettype none
interface jbs_if;
	logic tck;
	logic tms;
	logic tdi;
	logic trst_n;
	logic tdo;
	logic tdo_oe;
	modport port_end (
		input tck, tms, tdi, trst_n,
		output tdo, tdo_oe
	);
	modport tester_end (
		output tck, tms, tdi, trst_n,
		input tdo, tdo_oe
	);
endinterface
`default_nettype wire

// ### design/jbs_tap.sv
// Device end: test access port controller with bypass path.
// Assumes tck, tms, tdi and trst_n are asynchronous to clk and slow.
//
// Functional notes
// - Update with all ones selects bypass
// - Three-bit instruction, shifted LSB first
// - Bypass gives TDO one-stage delayed TDI
// - Inputs settle before each TCK pulse
// - Idle, DR select, IR select, capture, shift
// - Exit, update, then idle while TMS low
// - Data scan walks select, capture, shift, exit, update
// - TMS high holds test-logic reset
// - Test reset low only before scanning
`timescale 1ns/1ns
`default_nettype none
module jbs_tap
	import jbs_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	jbs_if.port_end link,
	output logic [2:0] instruction,
	output jbs_state_t tap_state,
	output logic bypass_active
);
	// ==========================================================
	// Input synchronisers
	logic [3:0] sync1;
	logic [3:0] sync2;
	logic tck_prev;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
			tck_prev <= 1'b0;
		end
		else
		begin
			sync1 <= {link.trst_n, link.tdi, link.tms, link.tck};
			sync2 <= sync1;
			tck_prev <= sync2[0];
		end
	end
	// Sampling only on synchronised edges keeps held inputs stable.
	wire tck_rise = sync2[0] & ~tck_prev;
	wire tck_fall = ~sync2[0] & tck_prev;
	wire tms_s = sync2[1];
	wire tdi_s = sync2[2];
	wire trst_s = ~sync2[3];
	// ==========================================================
	// Controller
	jbs_state_t state;
	jbs_state_t next_state;
	always_comb
	begin
		case (state)
			JBS_RESET: next_state = tms_s ? JBS_RESET : JBS_IDLE;
			JBS_IDLE: next_state = tms_s ? JBS_SEL_DR : JBS_IDLE;
			JBS_SEL_DR: next_state = tms_s ? JBS_SEL_IR : JBS_CAP_DR;
			JBS_CAP_DR: next_state = tms_s ? JBS_EXIT1_DR : JBS_SHIFT_DR;
			JBS_SHIFT_DR: next_state = tms_s ? JBS_EXIT1_DR : JBS_SHIFT_DR;
			JBS_EXIT1_DR: next_state = tms_s ? JBS_UPD_DR : JBS_PAUSE_DR;
			JBS_PAUSE_DR: next_state = tms_s ? JBS_EXIT2_DR : JBS_PAUSE_DR;
			JBS_EXIT2_DR: next_state = tms_s ? JBS_UPD_DR : JBS_SHIFT_DR;
			JBS_UPD_DR: next_state = tms_s ? JBS_SEL_DR : JBS_IDLE;
			JBS_SEL_IR: next_state = tms_s ? JBS_RESET : JBS_CAP_IR;
			JBS_CAP_IR: next_state = tms_s ? JBS_EXIT1_IR : JBS_SHIFT_IR;
			JBS_SHIFT_IR: next_state = tms_s ? JBS_EXIT1_IR : JBS_SHIFT_IR;
			JBS_EXIT1_IR: next_state = tms_s ? JBS_UPD_IR : JBS_PAUSE_IR;
			JBS_PAUSE_IR: next_state = tms_s ? JBS_EXIT2_IR : JBS_PAUSE_IR;
			JBS_EXIT2_IR: next_state = tms_s ? JBS_UPD_IR : JBS_SHIFT_IR;
			JBS_UPD_IR: next_state = tms_s ? JBS_SEL_DR : JBS_IDLE;
			default: next_state = JBS_RESET;
		endcase
	end
	// ==========================================================
	// Data paths
	logic [2:0] instruction_shift_register;
	logic bypass_bit;
	logic tdo;
	logic tdo_oe;
	wire in_shift_ir = (state == JBS_SHIFT_IR);
	wire in_shift_dr = (state == JBS_SHIFT_DR);
	wire is_bypass = (instruction == JBS_IR_BYPASS);
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state <= JBS_RESET;
			instruction_shift_register <= JBS_IR_CAPTURE;
			instruction <= JBS_IR_RESET;
			bypass_bit <= 1'b0;
		end
		else if (trst_s)
		begin
			state <= JBS_RESET;
			instruction <= JBS_IR_RESET;
		end
		else if (tck_rise)
		begin
			state <= next_state;
			if (state == JBS_CAP_IR)
				instruction_shift_register <= JBS_IR_CAPTURE;
			if (in_shift_ir)
				instruction_shift_register <= {tdi_s, instruction_shift_register[2:1]};
			if (state == JBS_UPD_IR)
				instruction <= instruction_shift_register;
			if (state == JBS_RESET)
				instruction <= JBS_IR_RESET;
			if (state == JBS_CAP_DR)
				bypass_bit <= 1'b0;
			if (in_shift_dr)
				bypass_bit <= tdi_s;
		end
	end
	// Output changes on the falling edge, so it holds through the next rise.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end
		else if (tck_fall)
		begin
			tdo_oe <= in_shift_ir | in_shift_dr;
			tdo <= in_shift_ir ? instruction_shift_register[0] :
				(in_shift_dr & bypass_bit);
		end
	end
	assign link.tdo = tdo;
	assign link.tdo_oe = tdo_oe;
	assign tap_state = state;
	assign bypass_active = is_bypass;
endmodule // jbs_tap
`default_nettype wire

// ### bench/jbs_checker.sv
// Checker for the link between the port and its tester.
// Assumes it sits beside the interface and sees only its signals.
`timescale 1ns/1ns
`default_nettype none
module jbs_checker (
	input wire logic clk,
	input wire logic nrst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic trst_n,
	input wire logic tdo,
	input wire logic tdo_oe
);
	// ==========================================================
	// Helper: TMS-high link clocks in a row, saturating at seven.
	logic [2:0] ones;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			ones <= 3'h0;
		else if ($rose(tck))
			ones <= tms ? ones + 3'(ones != 3'h7) : 3'h0;
	end
	// ==========================================================
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_high;
		tck [*8];
	endsequence
	property p_tck_high;
		$rose(tck) |-> s_high ##1 !tck;
	endproperty
	a_tck_high: assert property (p_tck_high)
		else $error("link clock high time wrong");
	property p_tck_low;
		$fell(tck) |-> !tck [*8];
	endproperty
	a_tck_low: assert property (p_tck_low)
		else $error("link clock low time short");
	property p_settled;
		$rose(tck) |-> $stable(tms) && $stable(tdi) && $stable(trst_n);
	endproperty
	a_settled: assert property (p_settled)
		else $error("inputs moved at clock rise");
	property p_tdo_steady;
		tck && $past(tck) |-> $stable(tdo);
	endproperty
	a_tdo_steady: assert property (p_tdo_steady)
		else $error("output moved while clock high");
	property p_oe_edge;
		$changed(tdo_oe) |-> !tck;
	endproperty
	a_oe_edge: assert property (p_oe_edge)
		else $error("enable moved while clock high");
	property p_oe_entry;
		$rose(tdo_oe) |-> ones == 3'h0;
	endproperty
	a_oe_entry: assert property (p_oe_entry)
		else $error("shift entered after select high");
	property p_oe_exit;
		ones >= 3'h2 |-> !tdo_oe;
	endproperty
	a_oe_exit: assert property (p_oe_exit)
		else $error("enable held after leaving shift");
	property p_tdo_quiet;
		!tdo_oe |-> tdo == 1'b0;
	endproperty
	a_tdo_quiet: assert property (p_tdo_quiet)
		else $error("output active while disabled");
endmodule // jbs_checker
`default_nettype wire

// ### bench/tb_top.sv
// Bench: joins the port and the tester and walks bypass sequences.
// Assumes one sequence at a time, each run to completion.
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import jbs_pkg::*;
;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic start = 1'b0;
	jbs_op_t op = JBS_OP_RESET;
	logic [31:0] wdata = 32'h0;
	logic [5:0] nbits = 6'h1;
	logic hold_trst = 1'b0;
	logic ready, done, bypass_active;
	logic [31:0] rdata;
	logic [2:0] instruction;
	jbs_state_t tap_state;
	int n_mismatch = 0;
	int n_checks = 0;
	jbs_if link ();
	jbs_tap i_jbs_tap (.clk(clk), .nrst(nrst), .link(link.port_end),
		.instruction(instruction), .tap_state(tap_state),
		.bypass_active(bypass_active));
	jbs_tester i_jbs_tester (.clk(clk), .nrst(nrst),
		.link(link.tester_end), .start(start), .op(op), .wdata(wdata),
		.nbits(nbits), .hold_trst(hold_trst), .ready(ready),
		.rdata(rdata), .done(done));
	jbs_checker i_jbs_checker (.clk(clk), .nrst(nrst), .tck(link.tck),
		.tms(link.tms), .tdi(link.tdi), .trst_n(link.trst_n),
		.tdo(link.tdo), .tdo_oe(link.tdo_oe));
	always #20 clk = ~clk;
	// ==========================================================
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
	begin
		n_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	end
	endtask
	task automatic run(input jbs_op_t o, input logic [31:0] w,
		input logic [5:0] n);
		int i;
	begin
		@(posedge clk);
		start <= 1'b1;
		op <= o;
		wdata <= w;
		nbits <= n;
		@(posedge clk);
		start <= 1'b0;
		i = 0;
		while (done !== 1'b1 && i < 3000)
		begin
			@(posedge clk);
			#1;
			i++;
		end
		check(32'(done), 32'h1);
	end
	endtask
	task automatic print_verdict;
	begin
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset;
	begin
		run(JBS_OP_RESET, 32'h0, 6'h1);
		check(32'(tap_state), 32'(JBS_IDLE));
		$display("reset walk done");
	end
	endtask
	task automatic t_ir_load;
	begin
		run(JBS_OP_IR, 32'h1, 6'h3);
		check(32'(instruction), 32'h1);
		check(32'(bypass_active), 32'h0);
		check(32'(rdata[31:29]), 32'(JBS_IR_CAPTURE));
		check(32'(tap_state), 32'(JBS_IDLE));
		$display("instruction load done");
	end
	endtask
	task automatic t_trst;
	begin
		@(posedge clk);
		hold_trst <= 1'b1;
		repeat (12) @(posedge clk);
		#1;
		check(32'(tap_state), 32'(JBS_RESET));
		@(posedge clk);
		hold_trst <= 1'b0;
		repeat (4) @(posedge clk);
		$display("test reset done");
	end
	endtask
	task automatic t_ir_bypass;
	begin
		run(JBS_OP_IR, 32'h7, 6'h3);
		check(32'(instruction), 32'(JBS_IR_BYPASS));
		check(32'(bypass_active), 32'h1);
		check(32'(tap_state), 32'(JBS_IDLE));
		$display("bypass load done");
	end
	endtask
	task automatic t_dr;
	begin
		// Bypass stage starts at zero, then echoes the previous bit.
		run(JBS_OP_DR, 32'h15, 6'h5);
		check(32'(rdata[31:27]), 32'h0A);
		check(32'(tap_state), 32'(JBS_IDLE));
		$display("bypass data done");
	end
	endtask
	// ==========================================================
	// Main sequence and watchdog
	initial
	begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_ir_load();
		t_trst();
		t_reset();
		t_ir_bypass();
		t_dr();
		print_verdict();
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		print_verdict();
	end
endmodule // tb_top
`default_nettype wire
